// file: hdl/uart_fc.sv
// Flow-controlled asynchronous serial transceiver, 8 data bits, 1 stop bit
`timescale 1ns/1ns
`include "uart_fc_params.svh"

module uart_fc (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  // Configuration
  input  wire uart_fc_pkg::uart_cfg_s  cfg_i,
  input  wire logic                    sleep_i,
  // Transmit user side
  input  wire logic [7:0]              tx_data_i,
  input  wire logic                    tx_valid_i,
  output logic                         tx_ready_o,
  // Receive user side
  output logic [7:0]                   rx_data_o,
  output logic                         rx_valid_o,
  input  wire logic                    rx_ready_i,
  // Status
  output uart_fc_pkg::uart_status_s    status_o,
  // Serial pins
  output logic                         txd_o,
  input  wire logic                    rxd_i,
  output logic                         rts_n_o,
  input  wire logic                    cts_n_i
);
  import uart_fc_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Clamp divisor so the rate never passes the top rate
  function automatic logic [15:0] eff_div(input logic [15:0] d);
    eff_div = (d < 16'(`UART_MIN_DIV)) ? 16'(`UART_MIN_DIV) : d;
  endfunction : eff_div

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] rxd_sync_r;
  logic [1:0] cts_sync_r;

  // Two stages for asynchronous pins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_sync_r <= 2'h3;
      cts_sync_r <= 2'h3;
    end else begin
      rxd_sync_r <= {rxd_sync_r[0], rxd_i};
      cts_sync_r <= {cts_sync_r[0], cts_n_i};
    end
  end

  logic rxd_s;
  logic cts_off;
  assign rxd_s   = rxd_sync_r[1];
  assign cts_off = cfg_i.flow_en & cts_sync_r[1];

  logic [15:0] div;
  assign div = eff_div(cfg_i.divisor);

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  uart_state_e tx_st_r;
  logic [15:0] tx_cnt_r;
  logic [2:0]  tx_bit_r;
  logic [7:0]  tx_sh_r;
  logic        tx_par_r;
  logic        tx_tick;
  assign tx_tick = (tx_cnt_r == div - 16'h0001);

  // Bit period counter
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) tx_cnt_r <= 16'h0000;
    else if (tx_st_r == ST_IDLE || tx_tick) tx_cnt_r <= 16'h0000;
    else tx_cnt_r <= tx_cnt_r + 16'h0001;
  end

  // Frame sequencer and line driver
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st_r    <= ST_IDLE;
      tx_bit_r   <= 3'h0;
      tx_sh_r    <= 8'h00;
      tx_par_r   <= 1'b0;
      txd_o      <= 1'b1;
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= 1'b0;
      case (tx_st_r)
        ST_IDLE: begin
          txd_o <= 1'b1;
          if (tx_valid_i && tx_ready_o) begin
            tx_sh_r  <= tx_data_i;
            tx_par_r <= ^tx_data_i;
            tx_st_r  <= ST_START;
            txd_o    <= 1'b0;
          end else begin
            tx_ready_o <= !cts_off;
          end
        end
        ST_START: if (tx_tick) begin
          tx_st_r  <= ST_DATA;
          tx_bit_r <= 3'h0;
          txd_o    <= tx_sh_r[0];
        end
        ST_DATA: if (tx_tick) begin
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          if (tx_bit_r == 3'(`UART_DATA_BITS - 1)) begin
            if (cfg_i.parity_en) begin
              tx_st_r <= ST_PARITY;
              txd_o   <= tx_par_r;
            end else begin
              tx_st_r <= ST_STOP;
              txd_o   <= 1'b1;
            end
          end else begin
            tx_bit_r <= tx_bit_r + 3'h1;
            txd_o    <= tx_sh_r[1];
          end
        end
        ST_PARITY: if (tx_tick) begin
          tx_st_r <= ST_STOP;
          txd_o   <= 1'b1;
        end
        ST_STOP: if (tx_tick) begin
          tx_st_r <= ST_IDLE;
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  uart_state_e rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [2:0]  rx_bit_r;
  logic [7:0]  rx_sh_r;
  logic        rx_tick;
  logic        rx_mid;
  assign rx_tick = (rx_cnt_r == div - 16'h0001);
  assign rx_mid  = (rx_cnt_r == {1'b0, div[15:1]});

  // Bit period counter, restarts on each falling start edge
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rx_cnt_r <= 16'h0000;
    else if (rx_st_r == ST_IDLE || rx_tick) rx_cnt_r <= 16'h0000;
    else rx_cnt_r <= rx_cnt_r + 16'h0001;
  end

  // Frame sampler, mid-bit sampling
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st_r         <= ST_IDLE;
      rx_bit_r        <= 3'h0;
      rx_sh_r         <= 8'h00;
      rx_data_o       <= 8'h00;
      rx_valid_o      <= 1'b0;
      status_o        <= '0;
    end else begin
      status_o.tx_busy <= (tx_st_r != ST_IDLE);
      status_o.rx_busy <= (rx_st_r != ST_IDLE);
      if (rx_valid_o && rx_ready_i) rx_valid_o <= 1'b0;
      case (rx_st_r)
        ST_IDLE: if (!rxd_s) rx_st_r <= ST_START;
        ST_START: if (rx_mid) begin
          if (rxd_s) rx_st_r <= ST_IDLE; // Glitch, not a start bit
        end else if (rx_tick) begin
          rx_st_r  <= ST_DATA;
          rx_bit_r <= 3'h0;
        end
        ST_DATA: if (rx_mid) begin
          rx_sh_r <= {rxd_s, rx_sh_r[7:1]};
        end else if (rx_tick) begin
          if (rx_bit_r == 3'(`UART_DATA_BITS - 1)) begin
            rx_st_r <= cfg_i.parity_en ? ST_PARITY : ST_STOP;
          end else begin
            rx_bit_r <= rx_bit_r + 3'h1;
          end
        end
        ST_PARITY: if (rx_mid) begin
          status_o.parity_err <= (rxd_s != ^rx_sh_r);
        end else if (rx_tick) begin
          rx_st_r <= ST_STOP;
        end
        ST_STOP: if (rx_mid) begin
          rx_st_r            <= ST_IDLE;
          status_o.frame_err <= !rxd_s;
          status_o.overrun   <= rx_valid_o && !rx_ready_i;
          if (!(rx_valid_o && !rx_ready_i)) begin
            rx_data_o  <= rx_sh_r;
            rx_valid_o <= 1'b1;
          end
          if (!cfg_i.parity_en) status_o.parity_err <= 1'b0;
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Request-to-send
  // --------------------------------------------------------------------------
  // Off (high) when holding an unread byte or asleep; on always if flow is off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rts_n_o <= 1'b1;
    else rts_n_o <= cfg_i.flow_en & (sleep_i | rx_valid_o);
  end

endmodule : uart_fc

// file: hdl/uart_fc_params.svh
// Constants for the flow-controlled serial transceiver
`ifndef UART_FC_PARAMS_SVH
`define UART_FC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define UART_CLK_HZ        100000000
`define UART_MAX_BPS       1000000
// Minimum divisor at the top rate: clock cycles per bit
`define UART_MIN_DIV       (`UART_CLK_HZ / `UART_MAX_BPS)
`define UART_DIV_W         16
`define UART_DIV_RST       16'h0364

// ----------------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------------
`define UART_DATA_BITS     8
`define UART_BIT_CNT_W     3
`define UART_PARITY_RST    1'b0
`define UART_FLOW_RST      1'b0

`endif

// file: hdl/uart_fc_pkg.sv
// Types shared by the flow-controlled serial transceiver
package uart_fc_pkg;

  // --------------------------------------------------------------------------
  // Configuration carrier
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        flow_en;    // Hardware flow control on
    logic        parity_en;  // Even parity on
    logic [15:0] divisor;    // Clock cycles per bit
  } uart_cfg_s;

  // --------------------------------------------------------------------------
  // Status carrier
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic tx_busy;
    logic rx_busy;
    logic parity_err;
    logic frame_err;
    logic overrun;
  } uart_status_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP
  } uart_state_e;

endpackage : uart_fc_pkg

// file: bench/uart_fc_checker.sv
// Assertion checker bound to the serial transceiver
`timescale 1ns/1ns
module uart_fc_checker (
  // Clock, reset, configuration
  input wire logic                  clk_i,
  input wire logic                  arst_n_i,
  input wire uart_fc_pkg::uart_cfg_s cfg_i,
  input wire logic                  sleep_i,
  // User and serial side
  input wire logic [7:0]            tx_data_i,
  input wire logic                  tx_valid_i,
  input wire logic                  tx_ready_o,
  input wire logic [7:0]            rx_data_o,
  input wire logic                  rx_valid_o,
  input wire logic                  rx_ready_i,
  input wire uart_fc_pkg::uart_status_s status_o,
  input wire logic                  txd_o,
  input wire logic                  rts_n_o,
  input wire logic                  cts_n_i
);
  import uart_fc_pkg::*;
  logic [15:0] cnt_r;
  logic [8:0]  dat_r;
  logic        take;
  assign take = tx_valid_i && tx_ready_o;
  // Cycles since a byte was taken, and that byte with its parity
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 16'h0000;
      dat_r <= 9'h000;
    end else begin
      cnt_r <= take ? 16'h0000 : cnt_r + 16'h0001;
      if (take) dat_r <= {^tx_data_i, tx_data_i};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  start_low_a: assert property (take |=> !txd_o [*8])
    else $error("start bit missing");
  take_busy_a: assert property (take |=> !tx_ready_o ##1 status_o.tx_busy)
    else $error("ready after take");
  bit_time_a: assert property ($changed(txd_o) |-> cnt_r % cfg_i.divisor == 16'h0000)
    else $error("bit edge off time");
  bit_order_a: assert property (
    status_o.tx_busy && cnt_r % cfg_i.divisor == 16'h0001 && cnt_r > cfg_i.divisor &&
    cnt_r / cfg_i.divisor < 16'h0009 + cfg_i.parity_en |-> txd_o == dat_r[cnt_r / cfg_i.divisor - 16'h0001])
    else $error("wrong bit on line");
  rts_flow_off_a: assert property (!cfg_i.flow_en && !$past(cfg_i.flow_en) && $past(arst_n_i) |-> !rts_n_o)
    else $error("rts off without flow");
  rts_busy_a: assert property (cfg_i.flow_en && (sleep_i || rx_valid_o) |=> rts_n_o)
    else $error("rts on while unable");
  cts_block_a: assert property ((cfg_i.flow_en && cts_n_i) [*5] |-> !tx_ready_o)
    else $error("ready while cts off");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
    else $error("received byte lost");
  // Main scenarios
  tx_take_c: cover property (take);
  rx_take_c: cover property (rx_valid_o && rx_ready_i);
  rts_off_c: cover property (cfg_i.flow_en && sleep_i);
endmodule : uart_fc_checker
bind uart_fc uart_fc_checker i_uart_fc_checker (.clk_i, .arst_n_i, .cfg_i, .sleep_i, .tx_data_i, .tx_valid_i,
  .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .status_o, .txd_o, .rts_n_o, .cts_n_i);

// file: bench/uart_host_model.sv
// Far-side host: sends and receives frames at a given bit time
`timescale 1ns/1ns
module uart_host_model (
  // Clock and serial pins
  input  wire logic clk_i,
  input  wire logic txd_i,
  input  wire logic rts_n_i,
  output logic      rxd_o
);
  initial rxd_o = 1'b1;
  // One frame, waits while rts is off; bad flips the parity bit
  task automatic send(input logic [7:0] b, input logic par, input logic bad, input int div);
    logic [10:0] f;
    f = par ? {1'b1, ^b ^ bad, b, 1'b0} : {2'b11, b, 1'b0};
    while (rts_n_i !== 1'b0) @(posedge clk_i);
    for (int i = 0; i < (par ? 11 : 10); i++) begin
      rxd_o <= f[i];
      repeat (div) @(posedge clk_i);
    end
  endtask : send
  // Samples a frame mid-bit: {stop, parity or 0, data}
  task automatic recv(input logic par, input int div, output logic [9:0] got);
    logic [9:0] s;
    @(negedge txd_i);
    repeat (div / 2) @(posedge clk_i);
    for (int i = 0; i < (par ? 10 : 9); i++) begin
      repeat (div) @(posedge clk_i);
      s[i] = txd_i;
    end
    got = par ? s : {s[8], 1'b0, s[7:0]};
  endtask : recv
endmodule : uart_host_model

// file: bench/uart_with_flow_control_bench.sv
// Self-checking bench for the flow-controlled transceiver
`timescale 1ns/1ns
module uart_with_flow_control_bench;
  import uart_fc_pkg::*;
  logic         clk = 1'b0, arst_n = 1'b0, sleep = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, cts_n = 1'b0;
  logic [7:0]   tx_data = 8'h00, rx_data, b;
  logic         tx_ready, rx_valid, txd, rxd, rts_n, blk;
  uart_cfg_s    cfg = '{1'b0, 1'b0, 16'h0064};
  uart_status_s status;
  logic [31:0]  seed = 32'h0000001a;
  logic [9:0]   got;
  int           failures = 0, total_checks = 0;
  always #5 clk = ~clk;
  uart_fc i_uart_fc (.clk_i(clk), .arst_n_i(arst_n), .cfg_i(cfg), .sleep_i(sleep), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .status_o(status), .txd_o(txd), .rxd_i(rxd), .rts_n_o(rts_n), .cts_n_i(cts_n));
  uart_host_model i_uart_host_model (.clk_i(clk), .txd_i(txd), .rts_n_i(rts_n), .rxd_o(rxd));
  // Xorshift byte source
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  // Expected frame: stop, even parity or 0, data
  function automatic logic [9:0] frame(input logic [7:0] d, input logic par);
    return {1'b1, par & ^d, d};
  endfunction : frame
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // Offers a byte, holds it until taken
  task automatic put(input logic [7:0] d);
    @(posedge clk);
    #1 tx_data = d;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    #1 tx_valid = 1'b0;
  endtask : put
  task automatic send_check(input logic par, input int div);
    fork
      put(b);
      i_uart_host_model.recv(par, div, got);
    join
    chk(got, frame(b, par));
    // Let the stop bit finish before settings change
    repeat (div) @(posedge clk);
    #1;
  endtask : send_check
  // Expected run about 14400 cycles
  initial begin
    #400000 failures++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({txd, rts_n, tx_ready}, 10'h005);
    for (int k = 0; k < 4; k++) begin
      b = k == 0 ? 8'h01 : rnd();
      cfg = '{1'b0, k[0], k[1] ? 16'h00a3 : 16'h0064};
      send_check(k[0], k[1] ? 163 : 100);
    end
    $display("transmit test done");
    repeat (1200) @(posedge clk);
    #1 cfg = '{1'b0, 1'b0, 16'h0064};
    for (int k = 0; k < 4; k++) begin
      b = k == 3 ? 8'h80 : rnd();
      cfg.parity_en = k[0];
      i_uart_host_model.send(b, k[0], k == 3, 100);
      #1 chk({status.frame_err, status.parity_err, rx_data}, {1'b0, k == 3, b});
      rx_ready = 1'b1;
      @(posedge clk);
      #1 rx_ready = 1'b0;
      chk(rx_valid, 1'b0);
    end
    $display("receive test done");
    cfg = '{1'b1, 1'b0, 16'h0064};
    cts_n = 1'b1;
    sleep = 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(rts_n, 1'b1);
    sleep = 1'b0;
    blk = 1'b0;
    b = rnd();
    fork
      put(b);
      i_uart_host_model.recv(1'b0, 100, got);
      begin
        repeat (200) begin
          @(posedge clk);
          blk = blk | tx_ready | !txd;
        end
        cts_n <= 1'b0;
      end
    join
    chk(got, frame(b, 1'b0));
    chk(blk, 1'b0);
    b = rnd();
    i_uart_host_model.send(b, 1'b0, 1'b0, 100);
    #1 chk({status.overrun, rts_n, rx_data}, {1'b0, 1'b1, b});
    rx_ready = 1'b1;
    repeat (3) @(posedge clk);
    #1 rx_ready = 1'b0;
    chk(rts_n, 1'b0);
    cfg.flow_en = 1'b0;
    cts_n = 1'b1;
    b = rnd();
    send_check(1'b0, 100);
    $display("flow control test done");
    wrap_up();
  end
endmodule : uart_with_flow_control_bench
